// File: include/timer16_defines.svh
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_CAPTURE_LOW 8'h24
`define IDX_CAPTURE_HIGH 8'h25
`define IDX_COMPARE_B_LOW 8'h28
`define IDX_COMPARE_B_HIGH 8'h29
`define IDX_COMPARE_A_LOW 8'h2a
`define IDX_COMPARE_A_HIGH 8'h2b
`define IDX_COUNT_LOW 8'h2c
`define IDX_COUNT_HIGH 8'h2d
`define IDX_CONTROL_B 8'h2e
`define IDX_CONTROL_A 8'h2f
`define IDX_FLAGS 8'h38
`define IDX_ENABLES 8'h39
`define IDX_GLOBAL 8'h3f

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CA_MODE_A_LSB 6
`define CA_MODE_B_LSB 4
`define CA_PWM_LSB 0
`define CB_NC_BIT 7
`define CB_EDGE_BIT 6
`define CB_CTC_BIT 3
`define CB_CS_LSB 0
`define FL_OVF_BIT 7
`define FL_CMPA_BIT 6
`define FL_CMPB_BIT 5
`define FL_CAP_BIT 3
`define GL_IE_BIT 7

// ----------------------------------------------------------------------
// Encodings and counts
// ----------------------------------------------------------------------
`define PWM_OFF 2'b00
`define PWM_8 2'b01
`define PWM_9 2'b10
`define PWM_10 2'b11
`define TOP_8 10'h0ff
`define TOP_9 10'h1ff
`define TOP_10 10'h3ff
`define CS_STOP 3'b000
`define CS_DIV1 3'b001
`define CS_DIV8 3'b010
`define CS_DIV64 3'b011
`define CS_DIV256 3'b100
`define CS_DIV1024 3'b101
`define CS_EXT_FALL 3'b110
`define CS_EXT_RISE 3'b111
`define DIV8_MASK 10'h007
`define DIV64_MASK 10'h03f
`define DIV256_MASK 10'h0ff
`define DIV1024_MASK 10'h3ff
`define COUNT_MAX 16'hffff
`define COUNT_ZERO 16'h0000
`define NC_SAMPLES 4
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: include/timer16_pkg.sv
package timer16_pkg;

  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;
  typedef logic [1:0] out_mode_t;
  typedef logic [2:0] clk_sel_t;

endpackage : timer16_pkg

// File: design/capture_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defines.svh"

module capture_unit #(
  parameter int SAMPLES = `NC_SAMPLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  input wire logic noise_cancel,
  input wire logic rising,
  output logic hit_q
);

  if (SAMPLES < 2) begin : g_bad_samples
    $error("capture_unit needs at least two samples");
  end

  logic s1_q, s2_q, s3_q, level_q, filt_q, filt_d;
  logic [SAMPLES-1:0] hist_q;

  // ----------------------------------------------------------------------
  // Synchroniser and filter
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      level_q <= 1'b0;
    else if (s2_q == s3_q)
      level_q <= s3_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hist_q <= '0;
    else
      hist_q <= {hist_q[SAMPLES-2:0], level_q};
  end

  always_comb
  begin
    filt_d = filt_q;
    if (!noise_cancel)
      filt_d = level_q;
    else if (&hist_q)
      filt_d = 1'b1;
    else if (~|hist_q)
      filt_d = 1'b0;
  end

  // A level change after a change of edge select is still one edge only.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filt_q <= 1'b0;
      hit_q <= 1'b0;
    end
    else
    begin
      filt_q <= filt_d;
      hit_q <= (filt_d != filt_q) && (filt_d == rising);
    end
  end

  single_hit_a : assert property (
    @(posedge aclk) disable iff (!aresetn) hit_q |=> !hit_q)
    else $error("capture hit lasted more than one cycle");

endmodule : capture_unit
`default_nettype wire

// File: design/pwm_channel.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defines.svh"

module pwm_channel #(
  parameter int CW = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic tick,
  input wire logic dir_up,
  input wire logic [CW-1:0] count_next,
  input wire logic [CW-1:0] compare,
  input wire logic [CW-1:0] top,
  input wire logic undivided,
  input wire timer16_pkg::out_mode_t mode,
  output logic out_q,
  output logic oe
);

  if (CW != 10) begin : g_bad_width
    $error("pwm_channel serves a 10-bit compare only");
  end

  logic match, up_act, down_act;

  assign match = enable && tick && (count_next == compare);
  assign oe = enable && mode[1];

  // At TOP both matches coincide, so the undivided clock leaves the pin.
  always_comb
  begin
    up_act = 1'b0;
    down_act = 1'b0;
    if (match && mode[1])
    begin
      if (compare == top)
        down_act = !undivided;
      else if (compare == '0)
        up_act = 1'b1;
      else if (dir_up)
        up_act = 1'b1;
      else
        down_act = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      out_q <= 1'b0;
    else if (up_act)
      out_q <= mode[0];
    else if (down_act)
      out_q <= !mode[0];
  end

  out_disc_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    !mode[1] |-> !oe ##1 $stable(out_q))
    else $error("output driven in a disconnected mode");

  up_clear_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (match && mode == 2'b10 && dir_up && compare != top) |=> !out_q)
    else $error("non-inverted output not cleared on up match");

endmodule : pwm_channel
`default_nettype wire

// File: design/timer16_capture_phase_pwm.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defines.svh"

module timer16_capture_phase_pwm #(
  parameter int ADDR_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic capture_input_pin,
  input wire logic ext_clock_pin,
  output logic pwm_out_a,
  output logic pwm_oe_a,
  output logic pwm_out_b,
  output logic pwm_oe_b,
  output logic overflow_irq,
  output logic compare_a_irq,
  output logic compare_b_irq,
  output logic capture_irq
);

  if (ADDR_W < 10) begin : g_bad_addr
    $error("address bus too narrow for the register map");
  end

  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[9:2];
  endfunction : reg_index

  function automatic logic [9:0] top_of(input logic [1:0] sel);
    case (sel)
      `PWM_8: top_of = `TOP_8;
      `PWM_9: top_of = `TOP_9;
      default: top_of = `TOP_10;
    endcase
  endfunction : top_of

  logic [15:0] capture_q, count_q, count_d, step, hold_a_q, hold_b_q;
  logic [15:0] act_a_q, act_b_q, top16;
  logic [7:0] temp_q, wr_idx, rd_idx, rdata_d;
  logic [9:0] presc_q, top10;
  logic [1:0] pwm_sel_q, rresp_d, bresp_d;
  timer16_pkg::out_mode_t mode_a_q, mode_b_q;
  timer16_pkg::clk_sel_t cs_q;
  timer16_pkg::count_dir_t dir_q, dir_d;
  logic nc_q, edge_q, ctc_q, gie_q, bvalid_q, rvalid_q;
  logic ovf_q, cmpa_q, cmpb_q, cap_q, en_ovf_q, en_cmpa_q, en_cmpb_q;
  logic en_cap_q, wr_go, wr_en, rd_go, tick, pwm_on, ovf_evt, latch;
  logic hit_cap, hit_ext, match_a, match_b, cnt_wr, clr_wr;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q, bresp_q;

  assign pwm_on = pwm_sel_q != `PWM_OFF;
  assign top10 = top_of(pwm_sel_q);
  assign top16 = {6'h00, top10};

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  assign wr_go = awvalid && wvalid && !bvalid_q;
  assign awready = wr_go;
  assign wready = wr_go;
  assign wr_en = wr_go && wstrb[0];
  assign wr_idx = reg_index(awaddr);
  assign rd_go = arvalid && !rvalid_q;
  assign arready = rd_go;
  assign rd_idx = reg_index(araddr);
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign cnt_wr = wr_en && wr_idx == `IDX_COUNT_LOW;
  assign clr_wr = wr_en && wr_idx == `IDX_FLAGS;

  always_comb
  begin
    case (wr_idx)
      `IDX_COMPARE_A_LOW, `IDX_COMPARE_A_HIGH, `IDX_COMPARE_B_LOW,
      `IDX_COMPARE_B_HIGH, `IDX_COUNT_LOW, `IDX_COUNT_HIGH,
      `IDX_CONTROL_A, `IDX_CONTROL_B, `IDX_FLAGS, `IDX_ENABLES,
      `IDX_GLOBAL, `IDX_CAPTURE_LOW, `IDX_CAPTURE_HIGH:
        bresp_d = `RESP_OKAY;
      default: bresp_d = `RESP_SLVERR;
    endcase
  end

  always_comb
  begin
    rresp_d = `RESP_OKAY;
    case (rd_idx)
      `IDX_CAPTURE_LOW: rdata_d = capture_q[7:0];
      `IDX_CAPTURE_HIGH: rdata_d = temp_q;
      `IDX_COMPARE_A_LOW: rdata_d = hold_a_q[7:0];
      `IDX_COMPARE_A_HIGH: rdata_d = hold_a_q[15:8];
      `IDX_COMPARE_B_LOW: rdata_d = hold_b_q[7:0];
      `IDX_COMPARE_B_HIGH: rdata_d = hold_b_q[15:8];
      `IDX_COUNT_LOW: rdata_d = count_q[7:0];
      `IDX_COUNT_HIGH: rdata_d = temp_q;
      `IDX_CONTROL_A: rdata_d = {mode_a_q, mode_b_q, 2'b00, pwm_sel_q};
      `IDX_CONTROL_B: rdata_d = {nc_q, edge_q, 2'b00, ctc_q, cs_q};
      `IDX_FLAGS: rdata_d = {ovf_q, cmpa_q, cmpb_q, 1'b0, cap_q, 3'b000};
      `IDX_ENABLES:
        rdata_d = {en_ovf_q, en_cmpa_q, en_cmpb_q, 1'b0, en_cap_q, 3'b000};
      `IDX_GLOBAL: rdata_d = {gie_q, 7'h00};
      default:
      begin
        rdata_d = 8'h00;
        rresp_d = `RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= bresp_d;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rdata_d};
      rresp_q <= rresp_d;
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Control registers and shared temporary byte
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_a_q <= 2'b00;
      mode_b_q <= 2'b00;
      pwm_sel_q <= `PWM_OFF;
      nc_q <= 1'b0;
      edge_q <= 1'b0;
      ctc_q <= 1'b0;
      cs_q <= `CS_STOP;
      en_ovf_q <= 1'b0;
      en_cmpa_q <= 1'b0;
      en_cmpb_q <= 1'b0;
      en_cap_q <= 1'b0;
      gie_q <= 1'b0;
    end
    else if (wr_en)
    begin
      case (wr_idx)
        `IDX_CONTROL_A:
        begin
          mode_a_q <= wdata[`CA_MODE_A_LSB+:2];
          mode_b_q <= wdata[`CA_MODE_B_LSB+:2];
          pwm_sel_q <= wdata[`CA_PWM_LSB+:2];
        end
        `IDX_CONTROL_B:
        begin
          nc_q <= wdata[`CB_NC_BIT];
          edge_q <= wdata[`CB_EDGE_BIT];
          ctc_q <= wdata[`CB_CTC_BIT];
          cs_q <= wdata[`CB_CS_LSB+:3];
        end
        `IDX_ENABLES:
        begin
          en_ovf_q <= wdata[`FL_OVF_BIT];
          en_cmpa_q <= wdata[`FL_CMPA_BIT];
          en_cmpb_q <= wdata[`FL_CMPB_BIT];
          en_cap_q <= wdata[`FL_CAP_BIT];
        end
        `IDX_GLOBAL: gie_q <= wdata[`GL_IE_BIT];
        default: ;
      endcase
    end
  end

  // Software must not interleave 16-bit accesses; the byte is shared.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      temp_q <= 8'h00;
    else if (wr_en && (wr_idx == `IDX_COMPARE_A_HIGH ||
             wr_idx == `IDX_COMPARE_B_HIGH || wr_idx == `IDX_COUNT_HIGH))
      temp_q <= wdata[7:0];
    else if (rd_go && rd_idx == `IDX_CAPTURE_LOW)
      temp_q <= capture_q[15:8];
    else if (rd_go && rd_idx == `IDX_COUNT_LOW)
      temp_q <= count_q[15:8];
  end

  // ----------------------------------------------------------------------
  // Timer clock and counter
  // ----------------------------------------------------------------------
  capture_unit #(.SAMPLES(`NC_SAMPLES)) u_ext_clock (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ext_clock_pin),
    .noise_cancel(1'b0),
    .rising(cs_q[0]),
    .hit_q(hit_ext)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      presc_q <= 10'h000;
    else
      presc_q <= presc_q + 10'h001;
  end

  always_comb
  begin
    case (cs_q)
      `CS_DIV1: tick = 1'b1;
      `CS_DIV8: tick = (presc_q & `DIV8_MASK) == `DIV8_MASK;
      `CS_DIV64: tick = (presc_q & `DIV64_MASK) == `DIV64_MASK;
      `CS_DIV256: tick = (presc_q & `DIV256_MASK) == `DIV256_MASK;
      `CS_DIV1024: tick = (presc_q & `DIV1024_MASK) == `DIV1024_MASK;
      `CS_EXT_FALL, `CS_EXT_RISE: tick = hit_ext;
      default: tick = 1'b0;
    endcase
  end

  always_comb
  begin
    step = count_q + 16'h0001;
    dir_d = timer16_pkg::DIR_UP;
    ovf_evt = 1'b0;
    if (pwm_on)
    begin
      dir_d = dir_q;
      if (dir_q == timer16_pkg::DIR_UP)
      begin
        if (count_q >= top16)
        begin
          step = count_q - 16'h0001;
          dir_d = timer16_pkg::DIR_DOWN;
        end
      end
      else if (count_q == `COUNT_ZERO)
      begin
        dir_d = timer16_pkg::DIR_UP;
        ovf_evt = tick;
      end
      else
        step = count_q - 16'h0001;
    end
    else if (ctc_q && count_q == act_a_q)
      step = `COUNT_ZERO;
    else
      ovf_evt = tick && count_q == `COUNT_MAX;
    if (pwm_on && dir_q == timer16_pkg::DIR_UP && count_q == `COUNT_ZERO)
      ovf_evt = tick;
    count_d = count_q;
    if (cnt_wr)
      count_d = {temp_q, wdata[7:0]};
    else if (tick)
      count_d = step;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q <= `COUNT_ZERO;
      dir_q <= timer16_pkg::DIR_UP;
    end
    else
    begin
      count_q <= count_d;
      if (tick || !pwm_on)
        dir_q <= dir_d;
    end
  end

  // ----------------------------------------------------------------------
  // Compare registers and outputs
  // ----------------------------------------------------------------------
  assign latch = tick && !cnt_wr && pwm_on && dir_q == timer16_pkg::DIR_UP
                 && step == top16;
  assign match_a = tick && !cnt_wr &&
                   (pwm_on ? step[9:0] == act_a_q[9:0] : step == act_a_q);
  assign match_b = tick && !cnt_wr &&
                   (pwm_on ? step[9:0] == act_b_q[9:0] : step == act_b_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_a_q <= 16'h0000;
      hold_b_q <= 16'h0000;
    end
    else if (wr_en && wr_idx == `IDX_COMPARE_A_LOW)
      hold_a_q <= {temp_q, wdata[7:0]};
    else if (wr_en && wr_idx == `IDX_COMPARE_B_LOW)
      hold_b_q <= {temp_q, wdata[7:0]};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      act_a_q <= 16'h0000;
      act_b_q <= 16'h0000;
    end
    else if (!pwm_on || latch)
    begin
      act_a_q <= hold_a_q;
      act_b_q <= hold_b_q;
    end
  end

  // The direction of the move into the next count, so a match met just
  // after a turn at TOP or zero takes the new direction.
  pwm_channel #(.CW(10)) u_pwm_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(pwm_on && !cnt_wr),
    .tick(tick),
    .dir_up(dir_d == timer16_pkg::DIR_UP),
    .count_next(step[9:0]),
    .compare(act_a_q[9:0]),
    .top(top10),
    .undivided(cs_q == `CS_DIV1),
    .mode(mode_a_q),
    .out_q(pwm_out_a),
    .oe(pwm_oe_a)
  );

  pwm_channel #(.CW(10)) u_pwm_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(pwm_on && !cnt_wr),
    .tick(tick),
    .dir_up(dir_d == timer16_pkg::DIR_UP),
    .count_next(step[9:0]),
    .compare(act_b_q[9:0]),
    .top(top10),
    .undivided(cs_q == `CS_DIV1),
    .mode(mode_b_q),
    .out_q(pwm_out_b),
    .oe(pwm_oe_b)
  );

  // ----------------------------------------------------------------------
  // Capture and flags
  // ----------------------------------------------------------------------
  capture_unit #(.SAMPLES(`NC_SAMPLES)) u_capture (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(capture_input_pin),
    .noise_cancel(nc_q),
    .rising(edge_q),
    .hit_q(hit_cap)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      capture_q <= 16'h0000;
    else if (hit_cap)
      capture_q <= count_q;
  end

  // A hardware event in the clearing cycle wins over the write of one.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovf_q <= 1'b0;
      cmpa_q <= 1'b0;
      cmpb_q <= 1'b0;
      cap_q <= 1'b0;
    end
    else
    begin
      ovf_q <= ovf_evt || (ovf_q && !(clr_wr && wdata[`FL_OVF_BIT]));
      cmpa_q <= match_a || (cmpa_q && !(clr_wr && wdata[`FL_CMPA_BIT]));
      cmpb_q <= match_b || (cmpb_q && !(clr_wr && wdata[`FL_CMPB_BIT]));
      cap_q <= hit_cap || (cap_q && !(clr_wr && wdata[`FL_CAP_BIT]));
    end
  end

  assign overflow_irq = ovf_q && en_ovf_q && gie_q;
  assign compare_a_irq = cmpa_q && en_cmpa_q && gie_q;
  assign compare_b_irq = cmpb_q && en_cmpb_q && gie_q;
  assign capture_irq = cap_q && en_cap_q && gie_q;

  capture_load_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    hit_cap |=> capture_q == $past(count_q) && cap_q)
    else $error("capture did not load counter and flag");

  temp_low_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_go && rd_idx == `IDX_CAPTURE_LOW && !wr_en)
    |=> temp_q == $past(capture_q[15:8]))
    else $error("capture low read did not load temp");

  pwm_range_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (pwm_on && $stable(pwm_sel_q) && count_q <= top16 && !cnt_wr)
    |=> count_q <= $past(top16))
    else $error("counter left zero to TOP range");

  overflow_pwm_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (tick && pwm_on && count_q == `COUNT_ZERO) |=> ovf_q)
    else $error("overflow flag missed when leaving zero");

  latch_top_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    latch |=> act_a_q == $past(hold_a_q) && count_q == top16)
    else $error("compare not latched at TOP");

  irq_gate_a : assert property (
    @(posedge aclk) disable iff (!aresetn)
    (hit_cap && en_cap_q && gie_q && !(wr_en && (wr_idx == `IDX_ENABLES
    || wr_idx == `IDX_GLOBAL))) |=> capture_irq)
    else $error("capture interrupt missing with flag and enables");

endmodule : timer16_capture_phase_pwm
`default_nettype wire

// File: tb/pwm_load_model.sv
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------------------
// Capture pin source and PWM output load
// --------------------------------------------------------------
module pwm_load_model (
  input wire logic aclk,
  input wire logic pwm,
  output logic pin,
  output int period,
  output int low_len
);
  logic prev = 1'b0;
  int cnt = 0;
  int low = 0;
  initial pin = 1'b0;
  // Levels are held whole cycles so the synchroniser sees them.
  task automatic drive(input logic v, input int cycles);
    pin <= v;
    repeat (cycles) @(posedge aclk);
  endtask : drive
  always @(posedge aclk)
  begin
    cnt <= cnt + 1;
    if (pwm && !prev)
    begin
      period <= cnt;
      low_len <= low;
      cnt <= 1;
    end
    if (!pwm)
      low <= prev ? 1 : low + 1;
    prev <= pwm;
  end
endmodule : pwm_load_model
`default_nettype wire

// File: tb/timer16_capture_phase_pwm_bench.sv
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------------------
// Register-level tests over the AXI4-Lite port
// --------------------------------------------------------------
module timer16_capture_phase_pwm_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] awaddr = 10'h000;
  logic [9:0] araddr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, pin;
  logic oe_a, oe_b, out_a, out_b, irq_cap, irq_ovf, irq_cmpa, irq_cmpb;
  logic [1:0] bresp, rresp, br;
  logic [31:0] rdata, d;
  int period, low_len;
  int fails = 0;
  int compares = 0;

  timer16_capture_phase_pwm dut_u (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .capture_input_pin(pin), .ext_clock_pin(1'b0), .pwm_out_a(out_a),
    .pwm_oe_a(oe_a), .pwm_out_b(out_b), .pwm_oe_b(oe_b),
    .overflow_irq(irq_ovf), .compare_a_irq(irq_cmpa),
    .compare_b_irq(irq_cmpb),
    .capture_irq(irq_cap));
  pwm_load_model load_u (.aclk, .pwm(out_a), .pin, .period, .low_len);

  initial forever #4 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(posedge aclk);
    while (awready !== 1'b1) @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge aclk);
    while (bvalid !== 1'b1) @(posedge aclk);
    br = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
  endtask : rd

  task automatic rdc(input string nm, input logic [7:0] idx,
    input logic [31:0] e);
    rd(idx);
    chk(nm, e, d);
  endtask : rdc

  // A 16-bit value goes high byte first, so the low write commits it.
  task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
    wr(idx + 8'h01, v[15:8]);
    wr(idx, v[7:0]);
  endtask : wr16

  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // The whole run is about seven thousand cycles, mostly PWM periods.
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    finish_test;
  end

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("cap_lo_rst", 8'h24, 32'h0);
    rdc("cap_hi_rst", 8'h25, 32'h0);
    rd(8'h10);
    chk("unmapped_resp", 32'h2, {30'h0, rresp});
    wr(8'h10, 8'h55);
    chk("unmapped_bresp", 32'h2, {30'h0, br});
    // Counter is stopped, so the captured value is known exactly.
    wr(8'h2e, 8'h40);
    wr16(8'h2c, 16'h1234);
    load_u.drive(1'b1, 12);
    rd(8'h38);
    chk("cap_flag", 32'h8, d & 32'h8);
    wr(8'h24, 8'hff);
    rdc("cap_lo", 8'h24, 32'h34);
    rdc("cap_hi", 8'h25, 32'h12);
    wr(8'h39, 8'h08);
    wr(8'h3f, 8'h80);
    chk("cap_irq", 32'h1, {31'h0, irq_cap});
    wr(8'h38, 8'h08);
    chk("cap_irq_clr", 32'h0, {31'h0, irq_cap});
    wr(8'h2e, 8'h00);
    wr16(8'h2c, 16'h0056);
    load_u.drive(1'b0, 12);
    rdc("cap_fall_lo", 8'h24, 32'h56);
    rdc("cap_fall_hi", 8'h25, 32'h00);
    wr(8'h38, 8'h08);
    wr(8'h2e, 8'hc0);
    wr16(8'h2c, 16'h0077);
    load_u.drive(1'b1, 2);
    load_u.drive(1'b0, 12);
    rd(8'h38);
    chk("glitch_flag", 32'h0, d & 32'h8);
    load_u.drive(1'b1, 14);
    rdc("nc_cap_lo", 8'h24, 32'h77);
    // Eight-bit phase-correct PWM, channel A non-inverted at 0x80.
    wr16(8'h2a, 16'h0080);
    rdc("cmp_rdback", 8'h2a, 32'h80);
    wr(8'h2f, 8'h81);
    wr(8'h2e, 8'h01);
    repeat (1200) @(posedge aclk);
    chk("pwm_period", 32'd510, period);
    chk("pwm_low", 32'd254, low_len);
    chk("oe_a", 32'h1, {31'h0, oe_a});
    chk("oe_b", 32'h0, {31'h0, oe_b});
    wr(8'h38, 8'hff);
    repeat (600) @(posedge aclk);
    rd(8'h38);
    chk("ovf_flag", 32'h80, d & 32'h80);
    chk("cmp_flags", 32'h60, d & 32'h60);
    wr(8'h39, 8'he8);
    chk("ovf_irq", 32'h1, {31'h0, irq_ovf});
    chk("cmpa_irq", 32'h1, {31'h0, irq_cmpa});
    chk("cmpb_irq", 32'h1, {31'h0, irq_cmpb});
    // Channel B inverted at zero; channel A at TOP, undivided clock.
    wr(8'h2f, 8'hb1);
    wr16(8'h2a, 16'h00ff);
    rdc("cmp_top_rdback", 8'h2a, 32'hff);
    repeat (1100) @(posedge aclk);
    chk("top_undiv", 32'h0, {31'h0, out_a});
    chk("zero_inv", 32'h1, {31'h0, out_b});
    chk("oe_b_on", 32'h1, {31'h0, oe_b});
    // With a divided clock the TOP match drives the output high.
    wr(8'h2e, 8'h02);
    repeat (4200) @(posedge aclk);
    chk("top_div", 32'h1, {31'h0, out_a});
    finish_test;
  end
endmodule : timer16_capture_phase_pwm_bench
`default_nettype wire
